// ==== hdl/monitor_regs.svh ====
// offsets, field positions and scaling constants of the monitor bank
`ifndef MONITOR_REGS_SVH
`define MONITOR_REGS_SVH

// ==========================================================
// register pointers
`define REG_RAIL_VOLTAGE   8'h02
`define REG_POWER          8'h03
`define REG_FAULT_SELECT   8'h06
`define READ_UNMAPPED      16'h0000

// ==========================================================
// fault select / flags fields
`define BIT_OVER_CURRENT   15
`define BIT_UNDER_CURRENT  14
`define BIT_RAIL_OVER      13
`define BIT_RAIL_UNDER     12
`define BIT_POWER_OVER     11
`define BIT_CONV_DONE_EN   10
`define BIT_LIMIT_FLAG     4
`define BIT_CONV_FLAG      3
`define BIT_OVERFLOW_FLAG  2
`define BIT_POLARITY       1
`define BIT_LATCH          0
`define UNUSED_FIELD       5'h00

// ==========================================================
// configuration fields seen by this bank
`define CFG_SOFT_RESET_BIT 15
`define CFG_MODE_OFF       2'h0

// ==========================================================
// power scaling: 1.25 mA x 1.25 mV = 1.5625 uW per product count, 10 mW per result count
`define POWER_DIVISOR      32'h00001900
`define POWER_MAX          16'hA3D7
`define POWER_MAX_WIDE     32'h0000A3D7

`endif

// ==== hdl/monitor_pkg.sv ====
// types shared by the monitor result and fault-select bank
package monitor_pkg;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic        wr;
		logic [15:0] wdata;
	} cfg_write_s;

	typedef struct packed {
		logic        current_done;
		logic        bus_done;
		logic        cycle_end;
		logic [15:0] current_code;
		logic [15:0] rail_code;
	} meas_s;

	typedef enum logic [2:0] {
		sel_none,
		sel_over_current,
		sel_under_current,
		sel_rail_over,
		sel_rail_under,
		sel_power_over
	} limit_sel_e;

	// ==========================================================
	// module state
	typedef struct packed {
		logic        done;
		logic [15:0] power;
		logic        overflow;
	} mult_state_s;

	typedef struct packed {
		logic [14:0] rail_voltage_bits;
		logic [15:0] power_product_bits;
		logic [15:0] current_code;
		logic        over_current_enable;
		logic        under_current_enable;
		logic        rail_over_voltage_enable;
		logic        rail_under_voltage_enable;
		logic        power_over_limit_enable;
		logic        conv_done_output_enable;
		logic        limit_function_flag;
		logic        conversion_done_flag;
		logic        math_overflow_flag;
		logic        fault_output_polarity;
		logic        fault_latch_select;
		logic        mult_busy;
		logic        conv_pending;
		logic [15:0] rdata;
		logic        rvalid;
		logic        alert_pin_out;
		logic        alert_pin_oe_n;
	} regs_state_s;

endpackage

// ==== hdl/power_multiplier.sv ====
// registered power product stage: magnitude of current times rail voltage, scaled and clamped
`include "monitor_regs.svh"

module power_multiplier (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [15:0] current_code,
	input  wire logic [14:0] rail_code,
	output logic             done,
	output logic [15:0]      power,
	output logic             overflow
);
	import monitor_pkg::*;

	mult_state_s s;
	mult_state_s next_s;
	logic [15:0] magnitude;
	logic [31:0] product;
	logic [31:0] quotient;

	// ==========================================================
	// arithmetic
	// two's complement negate; -32768 maps to 8000h which still fits unsigned
	assign magnitude = current_code[15] ? 16'((~current_code) + 16'h0001) : current_code;
	assign product   = {16'h0000, magnitude} * {17'h00000, rail_code};
	assign quotient  = product / `POWER_DIVISOR;

	always_comb begin
		next_s      = s;
		next_s.done = start;
		if (start) begin
			if (quotient > `POWER_MAX_WIDE) begin
				next_s.power    = `POWER_MAX;
				next_s.overflow = 1'b1;
			end else begin
				next_s.power    = quotient[15:0];
				next_s.overflow = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done     = s.done;
	assign power    = s.power;
	assign overflow = s.overflow;

	// ==========================================================
	// checks
	a_power_clamp_limit: assert property (@(posedge clk) disable iff (rst)
		done |-> (power <= `POWER_MAX))
		else $error("power result above ceiling");

	a_overflow_pins_max: assert property (@(posedge clk) disable iff (rst)
		(done && overflow) |-> (power == `POWER_MAX))
		else $error("overflow without clamped power");

	a_sign_ignored: assert property (@(posedge clk) disable iff (rst)
		(start && current_code == 16'hFFFF && rail_code != 15'h0000) |=> !overflow)
		else $error("negative current gave odd power");
endmodule

// ==== hdl/monitor_result_and_alert_regs.sv ====
// rail voltage and power results plus fault select, flags and open-collector fault pin
`include "monitor_regs.svh"

// What this block does
// - rail voltage register holds latest 1.25 mV code
// - results take averaged values when averaging on
// - rail voltage top bit reads zero
// - power counts weigh 10 mW fixed
// - power is current times rail voltage, scaled
// - power stored as magnitude regardless of sign
// - power never returns above A3D7h
// - highest set limit enable alone is compared
// - over-current enable faults when current above limit
// - under-current enable faults when current below limit
// - rail over-voltage faults when voltage above limit
// - rail under-voltage faults when voltage below limit
// - power over-limit faults when power above limit
// - conversion-done enable also drives fault pin
// - limit flag clears on read or clean conversion
// - done flag sets after math completes
// - done flag clears on config write with mode not power-down, select read
// - overflow flag set on arithmetic overflow
// - polarity bit picks active-low or active-high drive
// - latch bit picks latch or transparent mode
// - transparent idles when fault gone; latch until read
// - soft reset bit restores all defaults
module monitor_result_and_alert_regs (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire monitor_pkg::reg_req_s  req,
	input  wire monitor_pkg::cfg_write_s cfg,
	input  wire monitor_pkg::meas_s     meas,
	input  wire logic [15:0]            limit_value,
	output logic [15:0]                 rdata,
	output logic                        rvalid,
	output logic                        alert_pin_out,
	output logic                        alert_pin_oe_n
);
	import monitor_pkg::*;

	// ==========================================================
	// state and decode
	localparam regs_state_s state_reset = '{alert_pin_oe_n: 1'b1, default: '0};

	regs_state_s s;
	regs_state_s next_s;
	limit_sel_e  sel;
	logic        soft_reset;
	logic        mask_read;
	logic        mask_write;
	logic        conv_clear;
	logic        set_conv;
	logic        busy_after;
	logic        eval_now;
	logic        fault_now;
	logic        alert_active;
	logic        mult_done;
	logic [15:0] mult_power;
	logic        mult_overflow;
	logic [15:0] mult_current;

	function automatic limit_sel_e pick_limit(input logic [4:0] en);
		limit_sel_e r;
		r = sel_none;
		if (en[4]) begin
			r = sel_over_current;
		end else if (en[3]) begin
			r = sel_under_current;
		end else if (en[2]) begin
			r = sel_rail_over;
		end else if (en[1]) begin
			r = sel_rail_under;
		end else if (en[0]) begin
			r = sel_power_over;
		end
		return r;
	endfunction

	function automatic logic [15:0] select_word(input regs_state_s st);
		return {st.over_current_enable, st.under_current_enable,
			st.rail_over_voltage_enable, st.rail_under_voltage_enable,
			st.power_over_limit_enable, st.conv_done_output_enable,
			`UNUSED_FIELD,
			st.limit_function_flag, st.conversion_done_flag, st.math_overflow_flag,
			st.fault_output_polarity, st.fault_latch_select};
	endfunction

	assign sel = pick_limit({s.over_current_enable, s.under_current_enable,
		s.rail_over_voltage_enable, s.rail_under_voltage_enable,
		s.power_over_limit_enable});

	assign soft_reset = cfg.wr && cfg.wdata[`CFG_SOFT_RESET_BIT];
	assign mask_read  = req.rd && (req.addr == `REG_FAULT_SELECT);
	assign mask_write = req.wr && (req.addr == `REG_FAULT_SELECT);
	// power-down writes leave the flag alone so a final result stays flagged
	assign conv_clear = mask_read || (cfg.wr && (cfg.wdata[1:0] != `CFG_MODE_OFF));

	// ==========================================================
	// power product
	assign mult_current = meas.current_done ? meas.current_code : s.current_code;

	power_multiplier u_mult (
		.clk          (clk),
		.rst          (rst || soft_reset),
		.start        (meas.bus_done),
		.current_code (mult_current),
		.rail_code    (meas.rail_code[14:0]),
		.done         (mult_done),
		.power        (mult_power),
		.overflow     (mult_overflow)
	);

	// a cycle is finished only once its product is back
	assign busy_after = meas.bus_done || (s.mult_busy && !mult_done);
	assign set_conv   = (meas.cycle_end && !busy_after) || (mult_done && s.conv_pending);

	// ==========================================================
	// limit comparison, once per completed measurement
	// limit is taken in the same format as the compared result
	always_comb begin
		eval_now  = 1'b0;
		fault_now = 1'b0;
		case (sel)
			sel_over_current: begin
				eval_now  = meas.current_done;
				fault_now = $signed(meas.current_code) > $signed(limit_value);
			end
			sel_under_current: begin
				eval_now  = meas.current_done;
				fault_now = $signed(meas.current_code) < $signed(limit_value);
			end
			sel_rail_over: begin
				eval_now  = meas.bus_done;
				fault_now = {1'b0, meas.rail_code[14:0]} > limit_value;
			end
			sel_rail_under: begin
				eval_now  = meas.bus_done;
				fault_now = {1'b0, meas.rail_code[14:0]} < limit_value;
			end
			sel_power_over: begin
				eval_now  = mult_done;
				fault_now = mult_power > limit_value;
			end
			default: begin
				eval_now  = 1'b0;
				fault_now = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		next_s        = s;
		next_s.rvalid = 1'b0;
		alert_active  = 1'b0;

		// results come from the averaging engine already averaged
		if (meas.current_done) begin
			next_s.current_code = meas.current_code;
		end
		if (meas.bus_done) begin
			next_s.rail_voltage_bits = meas.rail_code[14:0];
		end
		if (mult_done) begin
			next_s.power_product_bits = mult_power;
			next_s.math_overflow_flag = mult_overflow;
		end

		next_s.mult_busy = busy_after;
		if (meas.cycle_end && busy_after) begin
			next_s.conv_pending = 1'b1;
		end else if (mult_done) begin
			next_s.conv_pending = 1'b0;
		end

		// clear first so a simultaneous set wins
		if (conv_clear) begin
			next_s.conversion_done_flag = 1'b0;
		end
		if (set_conv) begin
			next_s.conversion_done_flag = 1'b1;
		end

		if (s.fault_latch_select) begin
			if (mask_read) begin
				next_s.limit_function_flag = 1'b0;
			end
		end else if (eval_now && !fault_now) begin
			next_s.limit_function_flag = 1'b0;
		end
		if (eval_now && fault_now) begin
			next_s.limit_function_flag = 1'b1;
		end

		if (mask_write) begin
			next_s.over_current_enable       = req.wdata[`BIT_OVER_CURRENT];
			next_s.under_current_enable      = req.wdata[`BIT_UNDER_CURRENT];
			next_s.rail_over_voltage_enable  = req.wdata[`BIT_RAIL_OVER];
			next_s.rail_under_voltage_enable = req.wdata[`BIT_RAIL_UNDER];
			next_s.power_over_limit_enable   = req.wdata[`BIT_POWER_OVER];
			next_s.conv_done_output_enable   = req.wdata[`BIT_CONV_DONE_EN];
			next_s.fault_output_polarity     = req.wdata[`BIT_POLARITY];
			next_s.fault_latch_select        = req.wdata[`BIT_LATCH];
		end

		// read data shows the state before any read side effect
		if (req.rd) begin
			next_s.rvalid = 1'b1;
			case (req.addr)
				`REG_RAIL_VOLTAGE: next_s.rdata = {1'b0, s.rail_voltage_bits};
				`REG_POWER:        next_s.rdata = s.power_product_bits;
				`REG_FAULT_SELECT: next_s.rdata = select_word(s);
				default:           next_s.rdata = `READ_UNMAPPED;
			endcase
		end

		if (soft_reset) begin
			next_s = state_reset;
		end

		alert_active = next_s.limit_function_flag ||
			(next_s.conv_done_output_enable && next_s.conversion_done_flag);
		// open collector: pull low when active (normal) or when idle (inverted)
		next_s.alert_pin_out  = 1'b0;
		next_s.alert_pin_oe_n = !(alert_active ^ next_s.fault_output_polarity);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= state_reset;
		end else begin
			s <= next_s;
		end
	end

	assign rdata          = s.rdata;
	assign rvalid         = s.rvalid;
	assign alert_pin_out  = s.alert_pin_out;
	assign alert_pin_oe_n = s.alert_pin_oe_n;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence bus_cycle_end;
		meas.cycle_end && meas.bus_done && !cfg.wr;
	endsequence

	sequence quiet_config;
		!cfg.wr;
	endsequence

	a_conv_after_math: assert property (
		bus_cycle_end ##1 quiet_config |=> s.conversion_done_flag)
		else $error("done flag missing after product");

	a_conv_not_early: assert property (
		(meas.cycle_end && meas.bus_done && !s.conversion_done_flag && !s.conv_pending)
			|=> !s.conversion_done_flag)
		else $error("done flag set before product");

	a_rail_msb_zero: assert property (
		(req.rd && req.addr == `REG_RAIL_VOLTAGE && !soft_reset) |=> (rvalid && !rdata[15]))
		else $error("rail voltage top bit set");

	a_read_clears_conv: assert property (
		(mask_read && !set_conv) |=> !s.conversion_done_flag)
		else $error("done flag survived select read");

	a_unused_reads_zero: assert property (
		(mask_read && !soft_reset) |=> (rdata[9:5] == 5'h00))
		else $error("unused select bits nonzero");

	a_over_current_sets: assert property (
		(sel == sel_over_current && meas.current_done && !soft_reset &&
			$signed(meas.current_code) > $signed(limit_value)) |=> s.limit_function_flag)
		else $error("over-current fault missed");

	a_latch_holds_flag: assert property (
		(s.fault_latch_select && s.limit_function_flag && !mask_read && !cfg.wr)
			|=> s.limit_function_flag)
		else $error("latched flag dropped without read");

	a_transparent_clears: assert property (
		(!s.fault_latch_select && eval_now && !fault_now && !cfg.wr)
			|=> !s.limit_function_flag)
		else $error("transparent flag stuck after clean result");

	a_priority_select: assert property (
		s.over_current_enable |-> (sel == sel_over_current))
		else $error("highest enable not selected");

	a_pin_active_low: assert property (
		(!s.fault_output_polarity && s.limit_function_flag) |-> !alert_pin_oe_n)
		else $error("normal polarity pin not pulled low");

	a_conv_drives_pin: assert property (
		(s.conv_done_output_enable && s.conversion_done_flag && s.fault_output_polarity)
			|-> alert_pin_oe_n)
		else $error("done flag did not drive inverted pin");

	a_soft_reset_idle: assert property (
		soft_reset |=> (select_word(s) == 16'h0000 && alert_pin_oe_n))
		else $error("soft reset left state");
endmodule

// ==== tb/host_model.sv ====
// host controller model: register reads, register writes and configuration writes
module host_model (
	input  wire logic                     clk,
	output monitor_pkg::reg_req_s         req,
	output monitor_pkg::cfg_write_s       cfg,
	input  wire logic [15:0]              rdata,
	input  wire logic                     rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	import monitor_pkg::*;

	initial begin
		req = '0;
		cfg = '0;
	end

	// ==========================================================
	// bus cycles
	// released fields are inverted so a stale value never looks valid
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
		@(negedge clk);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge clk);
		ok = rvalid;
		d = rdata;
		req.rd = 1'b0;
		req.addr = ~a;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(negedge clk);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = v;
		@(negedge clk);
		req.wr = 1'b0;
		req.addr = ~a;
		req.wdata = ~v;
	endtask

	task automatic cfgw(input logic [15:0] v);
		@(negedge clk);
		cfg.wr = 1'b1;
		cfg.wdata = v;
		@(negedge clk);
		cfg.wr = 1'b0;
		cfg.wdata = ~v;
	endtask
endmodule

// ==== tb/tb_monitor_result_and_alert_regs.sv ====
// self-checking bench of the result and fault-select bank
module tb_monitor_result_and_alert_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import monitor_pkg::*;

	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	monitor_pkg::reg_req_s  req;
	monitor_pkg::cfg_write_s cfg;
	monitor_pkg::meas_s     meas = '0;
	logic [15:0]            limit_value = 16'h03E8;
	logic [15:0]            rdata;
	logic                   rvalid;
	logic                   alert_pin_out;
	logic                   alert_pin_oe_n;
	wire                    alert_line;
	int                     fails = 0;
	int                     n_tests = 0;

	// pulled up when nobody sinks it
	assign alert_line = alert_pin_oe_n ? 1'b1 : alert_pin_out;

	always #25 clk = ~clk;

	monitor_result_and_alert_regs uut (
		.clk            (clk),
		.rst            (rst),
		.req            (req),
		.cfg            (cfg),
		.meas           (meas),
		.limit_value    (limit_value),
		.rdata          (rdata),
		.rvalid         (rvalid),
		.alert_pin_out  (alert_pin_out),
		.alert_pin_oe_n (alert_pin_oe_n)
	);

	host_model partner (
		.clk    (clk),
		.req    (req),
		.cfg    (cfg),
		.rdata  (rdata),
		.rvalid (rvalid)
	);

	// ==========================================================
	// helpers
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic        ok;
		partner.rd(a, d, ok);
		chk(ok === 1'b1 ? d : ~e, e);
	endtask

	task automatic pin(input logic e);
		chk({15'h0000, alert_line}, {15'h0000, e});
	endtask

	// waits past the product stage so power-driven updates have landed
	task automatic pulse(input logic cur_done, rail_done, end_cycle, input logic [15:0] cur, rail);
		@(negedge clk);
		meas = '{cur_done, rail_done, end_cycle, cur, rail};
		@(negedge clk);
		meas.current_done = 1'b0;
		meas.bus_done = 1'b0;
		meas.cycle_end = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset;
		rchk(8'h06, 16'h0000);
		partner.wr(8'h02, 16'h1234);
		rchk(8'h02, 16'h0000);
		rchk(8'h03, 16'h0000);
		rchk(8'h10, 16'h0000);
		pin(1'b1);
		$display("reset test done");
	endtask

	task automatic t_results;
		pulse(1'b1, 1'b1, 1'b0, 16'hFFFF, 16'h7FFF);
		rchk(8'h03, 16'h0005);
		pulse(1'b1, 1'b1, 1'b1, 16'hFCE0, 16'h1F40);
		rchk(8'h02, 16'h1F40);
		rchk(8'h03, 16'h03E8);
		rchk(8'h06, 16'h0008);
		rchk(8'h06, 16'h0000);
		pulse(1'b1, 1'b1, 1'b1, 16'h7FFF, 16'hFFFF);
		rchk(8'h02, 16'h7FFF);
		rchk(8'h03, 16'hA3D7);
		rchk(8'h06, 16'h000C);
		pulse(1'b0, 1'b0, 1'b1, 16'h7FFF, 16'hFFFF);
		partner.cfgw(16'h0004);
		rchk(8'h06, 16'h000C);
		pulse(1'b0, 1'b0, 1'b1, 16'h7FFF, 16'hFFFF);
		partner.cfgw(16'h0007);
		rchk(8'h06, 16'h0004);
		$display("results test done");
	endtask

	// enable, current, rail, fault expected
	localparam logic [48:0] ROWS [13] = '{
		{16'h8000, 16'h07D0, 16'h0000, 1'b1}, {16'h8000, 16'h0064, 16'h0000, 1'b0},
		{16'h4000, 16'h0064, 16'h0000, 1'b1}, {16'h4000, 16'h07D0, 16'h0000, 1'b0},
		{16'h4000, 16'hFC18, 16'h0000, 1'b1}, {16'h2000, 16'h0000, 16'h07D0, 1'b1},
		{16'h2000, 16'h0000, 16'h0064, 1'b0}, {16'h1000, 16'h0000, 16'h0064, 1'b1},
		{16'h1000, 16'h0000, 16'h07D0, 1'b0}, {16'h0800, 16'h0320, 16'h3E80, 1'b1},
		{16'h0800, 16'h0320, 16'h0FA0, 1'b0}, {16'hC000, 16'h0064, 16'h0000, 1'b0},
		{16'hC000, 16'h07D0, 16'h0000, 1'b1}
	};

	task automatic t_limits;
		limit_value = 16'h03E8;
		for (int i = 0; i < 13; i++) begin
			partner.wr(8'h06, ROWS[i][48:33]);
			pulse(1'b1, 1'b1, 1'b0, ROWS[i][32:17], ROWS[i][16:1]);
			pin(~ROWS[i][0]);
		end
		rchk(8'h06, 16'hC010);
		$display("limit test done");
	endtask

	task automatic t_latch;
		partner.wr(8'h06, 16'h8001);
		pulse(1'b1, 1'b0, 1'b0, 16'h07D0, 16'h0000);
		pulse(1'b1, 1'b0, 1'b0, 16'h0064, 16'h0000);
		pin(1'b0);
		rchk(8'h06, 16'h8011);
		@(negedge clk);
		pin(1'b1);
		rchk(8'h06, 16'h8001);
		partner.wr(8'h06, 16'h8002);
		pulse(1'b1, 1'b0, 1'b0, 16'h0064, 16'h0000);
		pin(1'b0);
		pulse(1'b1, 1'b0, 1'b0, 16'h07D0, 16'h0000);
		pin(1'b1);
		$display("latch test done");
	endtask

	task automatic t_conv;
		// a clean result first, so the limit flag left by the latch test is gone
		pulse(1'b1, 1'b0, 1'b0, 16'h0064, 16'h0000);
		pin(1'b0);
		partner.wr(8'h06, 16'h0400);
		pin(1'b1);
		pulse(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000);
		pin(1'b0);
		rchk(8'h06, 16'h0408);
		@(negedge clk);
		pin(1'b1);
		$display("conversion test done");
	endtask

	task automatic t_soft;
		partner.wr(8'h06, 16'hFFFF);
		rchk(8'h06, 16'hFC03);
		partner.cfgw(16'h8000);
		rchk(8'h06, 16'h0000);
		rchk(8'h02, 16'h0000);
		$display("soft reset test done");
	endtask

	// ==========================================================
	// closing
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		test_done;
	end

	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_reset;
		t_results;
		t_limits;
		t_latch;
		t_conv;
		t_soft;
		test_done;
	end
endmodule
